// file: rtl/tis_status_flags.sv
// module: tdm interface status register with latched event flags and clock failover
// Functional notes
// - bits 3:0 and 10 read zero
// - absent flag when clock pin stops toggling
// - watch pins as inputs and outputs
// - output enable low blocks absent and fail
// - flags stay until written one
// - single-rate pin driven with the clocks, derive bit unused
// - clock fail only when not master
// - fail flag on line high, pin code 11
// - fail plus alternate: drive clocks, pin zero
// - overrun flag when transfer misses time
// - overrun only with memory transfer enabled
// - underrun flag on receive buffer underrun
// - underrun counts only with detection enabled
// - wrap flag when underrun counter wraps
// - service bit is or of flags
// - bits 15:11 show live general pins
// - flags reach global indication through enables
// - test bit forces every status event; absent and fail need output enable high, fail also not master
// - output enable low tristates and loops back
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
module tis_status_flags
   import tis_pkg::*;
#(
   parameter int ABSENT_LIMIT = TIS_ABSENT_CYCLES // watchdog timeout in cycles
) (
   input wire logic clk_sys_i, // master clock, 20 mhz
   input wire logic nrst_i, // async reset, active low
   // register port
   input wire logic [15:0] addr_i, // register address
   input wire logic [15:0] wdata_i, // write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   output logic [15:0] rdata_o, // read data, cycle after rd_i
   // tdm clock pins, levels seen at the pads
   input wire logic double_rate_clock_pin_i, // double rate clock level
   input wire logic single_rate_clock_pin_i, // single rate clock level
   input wire logic frame_sync_pin_i, // frame sync level
   output logic tdm_clocks_oe_o, // drive clock and frame sync pins
   output logic single_rate_clock_oe_o, // drive single rate clock pin
   // general pins, pin a doubles as clock_fail_line
   input wire logic [4:0] general_pins_i, // levels of pins a..e
   output logic general_pin_a_o, // value driven on pin a
   output logic general_pin_a_oe_o, // drive pin a
   // event sources
   input wire logic bandwidth_miss_i, // transfer ran out of time, pulse
   input wire logic read_underrun_i, // receive buffer underrun, pulse
   input wire logic underrun_detect_en_i, // detection enable of that buffer
   input wire logic underrun_count_wrap_i, // underrun counter wrapped, pulse
   // tdm data path control
   output logic tdm_data_oe_o, // tdm data outputs enabled
   output logic tdm_loopback_o, // receive data looped to transmit
   output logic global_service_indication_o // enabled flag pending
);
   // ---------------- register storage ----------------
   logic [15:0] ctl_q; // interface control
   logic [15:0] pcfg_q; // pin configuration
   logic [15:0] bt_q; // bus type
   logic [NUM_FLAGS-1:0] flags_q; // latched flags, bits 8:4
   logic [NUM_FLAGS-1:0] flags_d; // next flags
   logic [15:0] rdata_q; // read data register
   logic [15:0] rdata_d; // next read data

   // ---------------- decoded control ----------------
   wire gen_oe = ctl_q[CTL_GEN_OE]; // general_output_enable
   wire mem_xfer_en = ctl_q[CTL_MEM_XFER_EN]; // memory_transfer_enable
   wire test_force = ctl_q[CTL_TEST]; // force_events_test_bit
   wire [NUM_FLAGS-1:0] irq_en = ctl_q[CTL_IE_HI:CTL_IE_LO]; // per flag enables
   wire [1:0] pin_a_cfg = pcfg_q[PCFG_A_LO +: 2]; // pin_a_configuration
   wire pin_a_is_fail = (pin_a_cfg == PCFG_A_CLK_FAIL); // code 11
   wire clk_master = bt_q[BT_CLK_MASTER]; // device is clock master
   wire alt_master = bt_q[BT_ALT_MASTER]; // alternate_master_select
   wire derive_x1 = bt_q[BT_DERIVE_X1]; // derive_single_rate_clock

   // ---------------- address decode ----------------
   wire hit_ctl = (addr_i == TIS_CONTROL_ADDR); // control selected
   wire hit_status = (addr_i == TIS_STATUS_ADDR); // status selected
   wire hit_pcfg = (addr_i == TIS_PIN_CFG_ADDR); // pin config selected
   wire hit_bt = (addr_i == TIS_BUS_TYPE_ADDR); // bus type selected
   wire wr_ctl = wr_i && hit_ctl; // control write
   wire wr_pcfg = wr_i && hit_pcfg; // pin config write
   wire wr_bt = wr_i && hit_bt; // bus type write
   wire wr_status = wr_i && hit_status; // write-one-to-clear access

   // ---------------- clock activity ----------------
   wire [NUM_CLK_PINS-1:0] clk_pins; // monitored pad levels
   wire [NUM_CLK_PINS-1:0] pin_absent; // per pin watchdog result
   // pad levels are watched whichever way the pins point
   assign clk_pins = {frame_sync_pin_i, single_rate_clock_pin_i, double_rate_clock_pin_i};

   // one watchdog per clock pin
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CLK_PINS; gi++) begin : g_watch
         tis_activity_watch #(
            .LIMIT(ABSENT_LIMIT)
         ) u_watch (
            .clk_sys_i(clk_sys_i),
            .nrst_i(nrst_i),
            .pin_i(clk_pins[gi]),
            .absent_o(pin_absent[gi])
         );
      end
   endgenerate

   // ---------------- set conditions ----------------
   wire [NUM_FLAGS-1:0] set_cond; // raw events per flag
   wire [NUM_FLAGS-1:0] clr_vec; // software clear per flag
   // any silent pin, or the test bit, raises absent; blocked by output enable
   assign set_cond[0] = gen_oe && ((|pin_absent) || test_force);
   // fail line high on pin a in code 11, only off-master, blocked by oe
   assign set_cond[1] = gen_oe && !clk_master
                        && ((pin_a_is_fail && general_pins_i[0]) || test_force);
   // transfer overrun, only while memory transfer runs
   assign set_cond[2] = (mem_xfer_en && bandwidth_miss_i) || test_force;
   // underrun recorded for buffers with detection enabled
   assign set_cond[3] = (read_underrun_i && underrun_detect_en_i) || test_force;
   // underrun counter returned to zero
   assign set_cond[4] = underrun_count_wrap_i || test_force;
   // write one clears, write zero
   assign clr_vec = wr_status ? wdata_i[ST_WRAP:ST_ABSENT] : '0;
   // set wins over a clear in the same cycle
   assign flags_d = (flags_q & ~clr_vec) | set_cond;

   // ---------------- status word ----------------
   wire service_bit = |flags_q; // summary of bits 8:4
   wire [15:0] status_word; // assembled status register
   // reserved bits 3:0 and 10 are constant zero, pins are live
   assign status_word = {general_pins_i, 1'b0, service_bit, flags_q, 4'h0};

   // read mux, unmapped addresses read zero
   assign rdata_d = hit_status ? status_word :
                    hit_ctl ? ctl_q :
                    hit_pcfg ? pcfg_q :
                    hit_bt ? bt_q : 16'h0000;

   // ---------------- outputs ----------------
   // flags reach the global indication only through their enables
   assign global_service_indication_o = |(flags_q & irq_en);
   // failover: latched fail with alternate select takes the clocks
   assign tdm_clocks_oe_o = clk_master || (flags_q[1] && alt_master);
   // single rate pin follows the clock drive; derive_single_rate_clock is not used
   assign single_rate_clock_oe_o = tdm_clocks_oe_o;
   // pin a in code 11 pulls the fail line low once we own the clocks
   assign general_pin_a_oe_o = pin_a_is_fail && tdm_clocks_oe_o;
   assign general_pin_a_o = 1'b0;
   // output enable low tristates data and loops receive back to transmit
   assign tdm_data_oe_o = gen_oe;
   assign tdm_loopback_o = !gen_oe;
   assign rdata_o = rdata_q;

   // ---------------- configuration registers ----------------
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctl_q <= TIS_CTL_RST;
         pcfg_q <= TIS_PCFG_RST;
         bt_q <= TIS_BT_RST;
      end else begin
         if (wr_ctl) begin // control write
            ctl_q <= wdata_i & CTL_WR_MASK;
         end
         if (wr_pcfg) begin // pin config write
            pcfg_q <= wdata_i & PCFG_WR_MASK;
         end
         if (wr_bt) begin // bus type write
            bt_q <= wdata_i & BT_WR_MASK;
         end
      end
   end

   // ---------------- flags ----------------
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flags_q <= TIS_FLAGS_RST;
      end else begin
         flags_q <= flags_d; // latch and hold
      end
   end

   // ---------------- read data ----------------
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_q <= 16'h0000;
      end else if (rd_i) begin // data stand only in the next cycle
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   // ---------------- assertions ----------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);

   // reserved bits of a status read are zero
   a_reserved_bits_zero: assert property (
      rd_i && hit_status |=> (rdata_o[3:0] == 4'h0) && !rdata_o[10])
      else $error("reserved status bits read nonzero");

   // a silent clock pin with oe raises absent next cycle
   a_absent_raised: assert property (
      gen_oe && (|pin_absent) |=> flags_q[0])
      else $error("clock absent not raised");

   // with oe low, absent and fail cannot rise
   a_oe_blocks_clock: assert property (
      !gen_oe && !flags_q[0] && !flags_q[1] |=> !flags_q[0] && !flags_q[1])
      else $error("clock flag rose with output enable low");

   // no flag drops unless a one was written to it
   a_flags_sticky: assert property (
      1'b1 |=> (($past(flags_q) & ~$past(clr_vec) & ~flags_q) == 5'h00))
      else $error("flag dropped without clear");

   // fail line sampled high in code 11 off-master latches fail
   a_fail_latch: assert property (
      gen_oe && !clk_master && pin_a_is_fail && general_pins_i[0] |=> flags_q[1])
      else $error("clock fail not latched");

   // failover drives the clocks and pulls pin a low
   a_failover_drive: assert property (
      flags_q[1] && alt_master |-> tdm_clocks_oe_o
         && (general_pin_a_oe_o == pin_a_is_fail) && !general_pin_a_o)
      else $error("failover drive missing");

   // overrun cannot rise with memory transfer disabled
   a_overrun_gated: assert property (
      !mem_xfer_en && !test_force && !flags_q[2] |=> !flags_q[2])
      else $error("overrun raised while transfer disabled");

   // underrun ignored when detection is off
   a_underrun_gated: assert property (
      !(read_underrun_i && underrun_detect_en_i) && !test_force && !flags_q[3]
         |=> !flags_q[3])
      else $error("underrun raised without detection");

   // summary bit and live pins in the read word
   a_summary_pins: assert property (
      rd_i && hit_status |=> (rdata_o[ST_SERVICE] == $past(|flags_q))
         && (rdata_o[15:ST_PINS_LO] == $past(general_pins_i)))
      else $error("summary bit or pin levels wrong");

   // global indication tracks enabled flags
   a_service_enables: assert property (
      global_service_indication_o == |(flags_q & irq_en))
      else $error("global indication mismatch");

   // wrap event survives a clear in the same cycle
   a_set_beats_clear: assert property (
      underrun_count_wrap_i && clr_vec[4] |=> flags_q[4])
      else $error("wrap event lost to clear");

   // test bit forces the ungated flags within one cycle
   a_test_forces: assert property (
      test_force |=> (flags_q[4:2] == 3'h7))
      else $error("test bit did not force events");

   // ---------------- event assertions ----------------
   // enabled overrun event latches
   a_overrun_raised: assert property (
      mem_xfer_en && bandwidth_miss_i |=> flags_q[2])
      else $error("overrun not latched");

   // detected underrun latches
   a_underrun_raised: assert property (
      read_underrun_i && underrun_detect_en_i |=> flags_q[3])
      else $error("underrun not latched");

   // counter wrap latches
   a_wrap_raised: assert property (
      underrun_count_wrap_i |=> flags_q[4])
      else $error("wrap not latched");

   // no wrap flag without an event
   a_wrap_quiet: assert property (
      !underrun_count_wrap_i && !test_force && !flags_q[4] |=> !flags_q[4])
      else $error("wrap raised without event");

   // fail needs the line high in code 11
   a_fail_needs_line: assert property (
      !(pin_a_is_fail && general_pins_i[0]) && !test_force && !flags_q[1] |=> !flags_q[1])
      else $error("fail raised without line");

   // clock master never raises fail
   a_master_no_fail: assert property (
      clk_master && !flags_q[1] |=> !flags_q[1])
      else $error("fail raised as master");

   // write one clears when no event
   a_clear_works: assert property (
      wr_status && wdata_i[ST_WRAP] && !set_cond[4] |=> !flags_q[4])
      else $error("wrap not cleared");

   // write zero keeps the flag
   a_zero_keeps: assert property (
      flags_q[3] && !(wr_status && wdata_i[ST_UNDERRUN]) |=> flags_q[3])
      else $error("underrun dropped");

   // silent pad seen also while driving
   a_master_watched: assert property (
      clk_master && gen_oe && (|pin_absent) |=> flags_q[0])
      else $error("driven pad not watched");

   // ---------------- output assertions ----------------
   // slave deriving single rate leaves pin free
   a_derive_float: assert property (
      derive_x1 && !clk_master && !flags_q[1] |-> !single_rate_clock_oe_o)
      else $error("single rate pin driven");

   // inactive alternate keeps off the clocks
   a_alt_idle: assert property (
      !clk_master && !(flags_q[1] && alt_master) |-> !tdm_clocks_oe_o)
      else $error("clocks driven as slave");

   // owned clocks pull fail line low in code 11
   a_fail_pin_low: assert property (
      tdm_clocks_oe_o && pin_a_is_fail |-> general_pin_a_oe_o && !general_pin_a_o)
      else $error("fail line not pulled low");

   // control write sets data enable and loopback
   a_oe_loopback: assert property (
      wr_ctl |=> (tdm_data_oe_o == $past(wdata_i[CTL_GEN_OE]))
         && (tdm_loopback_o != tdm_data_oe_o))
      else $error("data enable or loopback wrong");

   // all enables off keeps indication low
   a_service_masked: assert property (
      (irq_en == 5'h00) |-> !global_service_indication_o)
      else $error("indication without enable");

   // idle read port returns zero
   a_read_idle: assert property (
      !rd_i |=> (rdata_o == 16'h0000))
      else $error("read data outside its cycle");

   // main scenarios
   c_absent_seen: cover property (gen_oe && (|pin_absent) ##1 flags_q[0]);
   c_failover: cover property (flags_q[1] && alt_master && !clk_master);
   c_clear_collide: cover property (underrun_count_wrap_i && clr_vec[4]);
   c_service_out: cover property (global_service_indication_o ##1 wr_status);
   c_overrun_seen: cover property (mem_xfer_en && bandwidth_miss_i ##1 flags_q[2]);
endmodule : tis_status_flags

// file: include/tis_pkg.sv
// package: register map, field positions and timing counts of the tdm status block
package tis_pkg;
   // register offsets (word addresses on the plain register port)
   localparam logic [15:0] TIS_CONTROL_ADDR = 16'h6000; // interface control
   localparam logic [15:0] TIS_STATUS_ADDR = 16'h6002; // tdm_interface_status
   localparam logic [15:0] TIS_PIN_CFG_ADDR = 16'h6004; // general pin configuration
   localparam logic [15:0] TIS_BUS_TYPE_ADDR = 16'h6010; // bus type / clock mode
   // control register fields
   localparam int CTL_MEM_XFER_EN = 1; // memory_transfer_enable
   localparam int CTL_GEN_OE = 2; // general_output_enable
   localparam int CTL_IE_LO = 4; // first interrupt enable bit
   localparam int CTL_IE_HI = 8; // last interrupt enable bit
   localparam int CTL_TEST = 15; // force_events_test_bit
   localparam logic [15:0] CTL_WR_MASK = 16'h81f6; // writable control bits
   // pin configuration fields
   localparam int PCFG_A_LO = 0; // pin_a_configuration low bit
   localparam logic [1:0] PCFG_A_CLK_FAIL = 2'h3; // pin a used as clock_fail_line
   localparam logic [15:0] PCFG_WR_MASK = 16'h0003; // writable pin config bits
   // bus type fields
   localparam int BT_DERIVE_X1 = 6; // derive_single_rate_clock
   localparam int BT_CLK_MASTER = 8; // clock master
   localparam int BT_ALT_MASTER = 9; // alternate_master_select
   localparam logic [15:0] BT_WR_MASK = 16'h0340; // writable bus type bits
   // status register fields
   localparam int ST_ABSENT = 4; // clock_absent_flag
   localparam int ST_CLK_FAIL = 5; // clock_fail_flag
   localparam int ST_OVERRUN = 6; // memory_bandwidth_overrun_flag
   localparam int ST_UNDERRUN = 7; // read underrun flag
   localparam int ST_WRAP = 8; // underrun_count_wrap_flag
   localparam int ST_SERVICE = 9; // service_summary_bit
   localparam int ST_PINS_LO = 11; // general pin a level
   localparam int NUM_FLAGS = 5; // latched flags in bits 8:4
   localparam int NUM_PINS = 5; // general pins a..e
   localparam int NUM_CLK_PINS = 3; // double rate, single rate, frame sync
   // reset values
   localparam logic [15:0] TIS_CTL_RST = 16'h0000; // control after reset
   localparam logic [15:0] TIS_PCFG_RST = 16'h0000; // pin config after reset
   localparam logic [15:0] TIS_BT_RST = 16'h0000; // bus type after reset
   localparam logic [4:0] TIS_FLAGS_RST = 5'h00; // flags after reset
   // activity watchdog: master clock cycles without a pin change
   localparam int TIS_ABSENT_CYCLES = 256; // timeout in clk_sys_i cycles
endpackage : tis_pkg

// file: rtl/tis_activity_watch.sv
// module: toggle watchdog for one tdm clock or frame-sync pin
`timescale 1ns/10ps
module tis_activity_watch
   import tis_pkg::*;
#(
   parameter int LIMIT = TIS_ABSENT_CYCLES // cycles without change before absent
) (
   input wire logic clk_sys_i, // master clock
   input wire logic nrst_i, // async reset, active low
   input wire logic pin_i, // monitored pin level
   output logic absent_o // level: pin has not toggled in LIMIT cycles
);
   localparam int CW = $clog2(LIMIT + 1); // counter width
   localparam logic [CW-1:0] CNT_MAX = CW'(LIMIT); // saturation value

   logic prev_q; // last sampled level
   logic [CW-1:0] cnt_q; // cycles since last change
   logic [CW-1:0] cnt_d; // next count
   wire changed = pin_i ^ prev_q; // edge of either direction

   // restart on any change, otherwise count up and stick at the limit
   assign cnt_d = changed ? '0 : ((cnt_q == CNT_MAX) ? cnt_q : cnt_q + 1'b1);
   assign absent_o = (cnt_q == CNT_MAX);

   // sample and count
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         prev_q <= pin_i;
         cnt_q <= cnt_d;
      end
   end
endmodule : tis_activity_watch

// file: tb/tis_backplane_model.sv
// behavioural model of the tdm backplane clock pads and clock fail line
`timescale 1ns/10ps
module tis_backplane_model (
   input wire logic clk_sys_i, // master clock
   input wire logic clk_run_i, // backplane clocks running
   input wire logic x1_run_i, // backplane drives single rate pin
   input wire logic fail_i, // backplane raises clock fail
   input wire logic dev_clk_oe_i, // device drives clock pins
   input wire logic pin_a_oe_i, // device drives pin a
   input wire logic pin_a_val_i, // value device drives on pin a
   output logic x2_o, // double rate clock pad
   output logic x1_o, // single rate clock pad
   output logic fs_o, // frame sync pad
   output logic fail_line_o // clock fail pad level
);
   logic [1:0] ph_q = 2'h0; // divider for slower pads
   logic x2_q = 1'b0; // double rate level
   logic x1_q = 1'b0; // single rate level
   logic fs_q = 1'b1; // frame sync level
   // pads run while either side drives them, a stopped clock holds its level
   always_ff @(posedge clk_sys_i) begin
      if (clk_run_i || dev_clk_oe_i) begin
         ph_q <= ph_q + 2'h1;
         x2_q <= ~x2_q;
         fs_q <= (ph_q == 2'h0) ? ~fs_q : fs_q;
         // single rate pad only moves when something really drives it
         if ((x1_run_i && clk_run_i) || dev_clk_oe_i) begin
            x1_q <= ph_q[0] ? ~x1_q : x1_q;
         end
      end
   end
   assign x2_o = x2_q;
   assign x1_o = x1_q;
   assign fs_o = fs_q;
   // device pull-down wins over the backplane request
   assign fail_line_o = pin_a_oe_i ? pin_a_val_i : fail_i;
endmodule : tis_backplane_model

// file: tb/tis_status_flags_test.sv
// self-checking testbench for the tdm interface status register
`timescale 1ns/10ps
module tis_status_flags_test;
   import tis_pkg::*;
   localparam int LIM = 8; // shortened watchdog limit
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [2:0] ev = 3'h0; // wrap, underrun, bandwidth miss
   logic det_en = 1'b0; // underrun detection enable
   logic clk_run = 1'b1; // backplane clocks running
   logic x1_run = 1'b1; // backplane drives single rate pin
   logic fail = 1'b0; // backplane clock fail request
   logic [15:0] rdata;
   logic x2, x1, fs, line_a, clk_oe, x1_oe, pa_o, pa_oe, data_oe, loopb, serv;
   int miscompares = 0;
   int comparisons = 0;
   tis_status_flags #(.ABSENT_LIMIT(LIM)) u_dut (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .double_rate_clock_pin_i(x2),
      .single_rate_clock_pin_i(x1), .frame_sync_pin_i(fs), .tdm_clocks_oe_o(clk_oe),
      .single_rate_clock_oe_o(x1_oe), .general_pins_i({4'ha, line_a}),
      .general_pin_a_o(pa_o), .general_pin_a_oe_o(pa_oe), .bandwidth_miss_i(ev[0]),
      .read_underrun_i(ev[1]), .underrun_detect_en_i(det_en),
      .underrun_count_wrap_i(ev[2]), .tdm_data_oe_o(data_oe), .tdm_loopback_o(loopb),
      .global_service_indication_o(serv));
   tis_backplane_model u_bp (
      .clk_sys_i(clk_sys_i), .clk_run_i(clk_run), .x1_run_i(x1_run), .fail_i(fail),
      .dev_clk_oe_i(clk_oe), .pin_a_oe_i(pa_oe), .pin_a_val_i(pa_o), .x2_o(x2),
      .x1_o(x1), .fs_o(fs), .fail_line_o(line_a));
   // 20 mhz master clock
   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // compare and count
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   // one-cycle register write
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask : wr
   // one-cycle read, data judged in the following cycle
   task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      chk(what, rdata, exp);
   endtask : rd_chk
   // one-cycle event pulse
   task automatic fire(input logic [2:0] e, input logic d);
      @(posedge clk_sys_i);
      ev <= e;
      det_en <= d;
      @(posedge clk_sys_i);
      ev <= 3'h0;
   endtask : fire
   // idle cycles
   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : hold
   // expected status word from flags and pin a level
   function automatic logic [15:0] st(input logic [4:0] f, input logic a);
      return {4'ha, a, 1'b0, |f, f, 4'h0};
   endfunction : st
   // reset state, reserved bits, unmapped address, output enable
   task automatic t_reset;
      rd_chk("status", TIS_STATUS_ADDR, st(5'h00, 1'b0));
      chk("loopback", {15'h0, loopb}, 16'h0001);
      rd_chk("unmapped", 16'h6006, 16'h0000);
      wr(TIS_CONTROL_ADDR, 16'h0004);
      #1;
      chk("data oe", {15'h0, data_oe}, 16'h0001);
      chk("loopback on", {15'h0, loopb}, 16'h0000);
      wr(TIS_CONTROL_ADDR, 16'h0000);
   endtask : t_reset
   // wrap flag, latching, clear, set beating clear, enabled indication
   task automatic t_wrap;
      wr(TIS_CONTROL_ADDR, 16'h0100);
      fire(3'h4, 1'b0);
      rd_chk("wrap", TIS_STATUS_ADDR, st(5'h10, 1'b0));
      chk("service", {15'h0, serv}, 16'h0001);
      wr(TIS_STATUS_ADDR, 16'hfeff);
      rd_chk("wrap kept", TIS_STATUS_ADDR, st(5'h10, 1'b0));
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= TIS_STATUS_ADDR;
      wdata_i <= 16'h0100;
      ev <= 3'h4;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      ev <= 3'h0;
      rd_chk("set wins", TIS_STATUS_ADDR, st(5'h10, 1'b0));
      wr(TIS_CONTROL_ADDR, 16'h0000);
      #1;
      chk("service masked", {15'h0, serv}, 16'h0000);
      wr(TIS_STATUS_ADDR, 16'h0100);
      rd_chk("wrap cleared", TIS_STATUS_ADDR, st(5'h00, 1'b0));
   endtask : t_wrap
   // overrun and underrun with their enables
   task automatic t_errors;
      fire(3'h1, 1'b0);
      rd_chk("overrun off", TIS_STATUS_ADDR, st(5'h00, 1'b0));
      wr(TIS_CONTROL_ADDR, 16'h0002);
      fire(3'h1, 1'b0);
      rd_chk("overrun", TIS_STATUS_ADDR, st(5'h04, 1'b0));
      fire(3'h2, 1'b0);
      rd_chk("underrun off", TIS_STATUS_ADDR, st(5'h04, 1'b0));
      fire(3'h2, 1'b1);
      rd_chk("underrun", TIS_STATUS_ADDR, st(5'h0c, 1'b0));
      wr(TIS_CONTROL_ADDR, 16'h0000);
      wr(TIS_STATUS_ADDR, 16'h01f0);
      rd_chk("errors cleared", TIS_STATUS_ADDR, st(5'h00, 1'b0));
   endtask : t_errors
   // clock watchdog in slave, derive and master modes
   task automatic t_absent;
      @(posedge clk_sys_i);
      clk_run <= 1'b0;
      hold(LIM + 4);
      rd_chk("absent gated", TIS_STATUS_ADDR, st(5'h00, 1'b0));
      wr(TIS_CONTROL_ADDR, 16'h0004);
      rd_chk("absent", TIS_STATUS_ADDR, st(5'h01, 1'b0));
      clk_run <= 1'b1;
      hold(LIM);
      wr(TIS_STATUS_ADDR, 16'h0010);
      rd_chk("absent cleared", TIS_STATUS_ADDR, st(5'h00, 1'b0));
      wr(TIS_BUS_TYPE_ADDR, 16'h0040);
      x1_run <= 1'b0;
      hold(LIM + 4);
      rd_chk("derive absent", TIS_STATUS_ADDR, st(5'h01, 1'b0));
      chk("x1 float", {15'h0, x1_oe}, 16'h0000);
      x1_run <= 1'b1;
      wr(TIS_BUS_TYPE_ADDR, 16'h0100);
      clk_run <= 1'b0;
      hold(2);
      wr(TIS_STATUS_ADDR, 16'h0010);
      hold(LIM + 4);
      rd_chk("master watched", TIS_STATUS_ADDR, st(5'h00, 1'b0));
      clk_run <= 1'b1;
      wr(TIS_BUS_TYPE_ADDR, 16'h0000);
   endtask : t_absent
   // clock fail latching and failover to master
   task automatic t_fail;
      wr(TIS_CONTROL_ADDR, 16'h0000);
      wr(TIS_PIN_CFG_ADDR, 16'h0003);
      wr(TIS_BUS_TYPE_ADDR, 16'h0300);
      wr(TIS_CONTROL_ADDR, 16'h8004);
      fail <= 1'b1;
      hold(2);
      rd_chk("fail master", TIS_STATUS_ADDR, st(5'h1d, 1'b0));
      wr(TIS_CONTROL_ADDR, 16'h0000);
      wr(TIS_STATUS_ADDR, 16'h01f0);
      wr(TIS_BUS_TYPE_ADDR, 16'h0200);
      rd_chk("fail gated", TIS_STATUS_ADDR, st(5'h00, 1'b1));
      wr(TIS_CONTROL_ADDR, 16'h0004);
      rd_chk("fail", TIS_STATUS_ADDR, st(5'h02, 1'b0));
      chk("failover", {12'h0, x1_oe, clk_oe, pa_oe, pa_o}, 16'h000e);
      fail <= 1'b0;
      wr(TIS_STATUS_ADDR, 16'h0020);
      rd_chk("fail cleared", TIS_STATUS_ADDR, st(5'h00, 1'b0));
      wr(TIS_BUS_TYPE_ADDR, 16'h0000);
   endtask : t_fail
   // test bit forces every event
   task automatic t_force;
      wr(TIS_CONTROL_ADDR, 16'h8004);
      hold(2);
      rd_chk("forced", TIS_STATUS_ADDR, st(5'h1f, 1'b0));
      wr(TIS_CONTROL_ADDR, 16'h0000);
      wr(TIS_STATUS_ADDR, 16'h01f0);
      rd_chk("forced cleared", TIS_STATUS_ADDR, st(5'h00, 1'b0));
   endtask : t_force
   // verdict and end of run
   task automatic report_and_stop;
      if (miscompares == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop
   // main sequence
   initial begin
      repeat (2) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      t_reset();
      t_wrap();
      t_errors();
      t_absent();
      t_fail();
      t_force();
      report_and_stop();
   end
   // watchdog, far beyond the under two hundred cycles the whole test sequence needs
   initial begin
      repeat (4000) @(posedge clk_sys_i);
      miscompares++;
      report_and_stop();
   end
endmodule : tis_status_flags_test
